//--- rtl/cfc_defs.svh
`ifndef CFC_DEFS_SVH
`define CFC_DEFS_SVH

// Register byte addresses
`define CFC_ADDR_PORTMAP    8'h20
`define CFC_ADDR_MODE       8'h21
`define CFC_ADDR_STATUS     8'h22

// Reset values
`define CFC_RST_PORTMAP     8'hF0
`define CFC_RST_MODE        8'h03
`define CFC_RST_STATUS      8'h00

// forward_port_enable_map fields
`define CFC_OFF_LSB         4
`define CFC_SEL_LSB         0

// forward_mode_control fields
`define CFC_REPL_BIT        7
`define CFC_ASAV_BIT        6
`define CFC_MODE1_LSB       4
`define CFC_MODE0_LSB       2
`define CFC_RR1_BIT         1
`define CFC_RR0_BIT         0

// Status fields
`define CFC_LOST_LSB        2
`define CFC_SYNC_LSB        0

`endif

//--- rtl/cfc_forward_ctrl.sv
// Overview of operation
// - Receive port 0 forwarding stops while its off bit 4 is 1; resets to 1.
// - Ports 1 to 3 have off bits 5, 6, 7, same polarity, reset 1.
// - Bit n of bits 3:0 routes receive port n to output 0 or 1.
// - Replicate bit 7 copies output 0 stream onto output 1.
// - Synchronized mode holds a line until all mapped enabled ports have data.
// - Send-when-ready bit 6 lets each port's line go as soon as available.
// - Send-when-ready ignored in concatenation, long packets only, both outputs.
// - Output 1 aligned mode bits 5:4: off, basic, interleave, concatenate; reset off.
// - Output 0 aligned mode bits 3:2 uses the same four encodings.
// - Bit 1 enables best-effort round-robin on output 1; resets to 1.
// - Bit 0 enables best-effort round-robin on output 0; resets to 1.
// - Best-effort serves pending mapped sources in rotating round-robin order.
// - Align-lost flag sets only after a good aligned group; clears on read.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "cfc_defs.svh"

module cfc_forward_ctrl (
  input  wire logic              CLK,
  input  wire logic              RSTN,
  input  wire logic [7:0]        ADDR,
  input  wire logic [7:0]        WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [7:0]        RDATA,
  input  wire logic [3:0]        RX_VALID,
  output logic      [3:0]        RX_READY,
  input  wire logic [3:0]        RX_LONG,
  input  wire logic [3:0][15:0]  RX_DATA,
  output logic      [1:0]        OUT_VALID,
  input  wire logic [1:0]        OUT_READY,
  output logic      [1:0]        OUT_LONG,
  output logic      [1:0][1:0]   OUT_SRC,
  output logic      [1:0][15:0]  OUT_DATA
);

  logic [7:0]  map_ff;
  logic [7:0]  mode_ff;
  logic [1:0]  lost_ff;
  logic [1:0]  synced_ff;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_map;
  logic [7:0]  nxt_mode;
  logic [1:0]  nxt_lost;
  logic [7:0]  nxt_rdata;
  logic [3:0]  rx_off;
  logic [3:0]  rx_sel;
  logic        repl;
  logic        asav;
  logic [1:0]  lost_set;
  logic [1:0]  slot_free;
  logic        rd_status;
  logic [3:0]  gnt_vec   [2];
  logic        push      [2];
  logic [1:0]  push_src  [2];
  logic        push_long [2];
  logic [15:0] push_data [2];

  assign rx_off    = map_ff[`CFC_OFF_LSB +: 4];
  assign rx_sel    = map_ff[`CFC_SEL_LSB +: 4];
  assign repl      = mode_ff[`CFC_REPL_BIT];
  assign asav      = mode_ff[`CFC_ASAV_BIT];
  assign rd_status = RD && (ADDR == `CFC_ADDR_STATUS);

  // Register file
  always_comb
  begin
    nxt_map   = map_ff;
    nxt_mode  = mode_ff;
    nxt_rdata = 8'h00;
    if (WR && (ADDR == `CFC_ADDR_PORTMAP))
    begin
      nxt_map = WDATA;
    end
    if (WR && (ADDR == `CFC_ADDR_MODE))
    begin
      nxt_mode = WDATA;
    end
    if (RD)
    begin
      case (ADDR)
        `CFC_ADDR_PORTMAP: nxt_rdata = map_ff;
        `CFC_ADDR_MODE:    nxt_rdata = mode_ff;
        `CFC_ADDR_STATUS:  nxt_rdata = {4'h0, lost_ff, synced_ff};
        default:           nxt_rdata = 8'h00;
      endcase
    end
    // A loss landing in the reading cycle survives the clear
    nxt_lost = (lost_ff & ~(rd_status ? 2'b11 : 2'b00)) | lost_set;
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      map_ff   <= `CFC_RST_PORTMAP;
      mode_ff  <= `CFC_RST_MODE;
      lost_ff  <= 2'b00;
      rdata_ff <= 8'h00;
    end
    else
    begin
      map_ff   <= nxt_map;
      mode_ff  <= nxt_mode;
      lost_ff  <= nxt_lost;
      rdata_ff <= nxt_rdata;
    end
  end

  assign RDATA = rdata_ff;

  // Disabled ports are drained so their video is dropped, not stalled
  assign RX_READY = rx_off | gnt_vec[0] | gnt_vec[1];

  function automatic logic [2:0] rr_pick(input logic [3:0] req, input logic [1:0] last);
    logic [2:0] res;
    logic [1:0] idx;
    res = 3'b000;
    for (int k = 4; k >= 1; k--)
    begin
      idx = 2'(last + 2'(k));
      if (req[idx])
      begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction : rr_pick

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  genvar o;
  generate
    for (o = 0; o < 2; o++)
    begin : g_eng
      cfc_pkg::cfc_state_t state_ff;
      cfc_pkg::cfc_state_t nxt_state;
      cfc_pkg::cfc_align_t align;
      logic [1:0]  ptr_ff;
      logic [1:0]  nxt_ptr;
      logic [3:0]  grp_ff;
      logic [3:0]  nxt_grp;
      logic        ok_ff;
      logic        nxt_ok;
      logic        nxt_synced;
      logic        sync_ff;
      logic        lset;
      logic        ovalid_ff;
      logic        olong_ff;
      logic [1:0]  osrc_ff;
      logic [15:0] odata_ff;
      logic [3:0]  member;
      logic [3:0]  cand;
      logic [3:0]  gnt;
      logic [2:0]  pick;
      logic        rr_en;
      logic        can_send;
      logic        take;
      logic        load;

      assign align  = cfc_pkg::cfc_align_t'(o == 0 ? mode_ff[`CFC_MODE0_LSB +: 2]
                                                   : mode_ff[`CFC_MODE1_LSB +: 2]);
      assign rr_en  = mode_ff[o];
      // Engine 1 yields to the copy of engine 0 while replicating
      assign member = (o == 1 && repl) ? 4'h0
                    : (~rx_off & (o == 0 ? ~rx_sel : rx_sel));
      assign cand   = member & RX_VALID;
      assign take   = OUT_READY[o] && (!(repl && o == 0) || OUT_READY[1]);
      assign slot_free[o] = !ovalid_ff || take;
      assign can_send = (repl && o == 0) ? (slot_free[0] && slot_free[1]) : slot_free[o];

      always_comb
      begin
        nxt_state  = state_ff;
        nxt_ptr    = ptr_ff;
        nxt_grp    = grp_ff & member;
        nxt_ok     = ok_ff;
        nxt_synced = sync_ff && (align != cfc_pkg::CFC_AL_OFF);
        lset       = 1'b0;
        gnt  = 4'h0;
        pick = 3'b000;
        if (align != cfc_pkg::CFC_AL_OFF)
        begin
          case (state_ff)
            cfc_pkg::CFC_ST_HUNT:
            begin
              if (member != 4'h0 && cand == member)
              begin
                nxt_grp   = member;
                nxt_state = cfc_pkg::CFC_ST_GROUP;
                // Heads of mixed packet kinds mean the sources drifted apart
                if ((RX_LONG & member) != 4'h0 && (RX_LONG & member) != member)
                begin
                  lset       = ok_ff;
                  nxt_synced  = 1'b0;
                end
              end
              else if (asav && align != cfc_pkg::CFC_AL_CAT)
              begin
                pick = rr_pick(cand & RX_LONG, ptr_ff);
                if (pick[2] && can_send)
                begin
                  gnt[pick[1:0]] = 1'b1;
                  nxt_ptr = pick[1:0];
                end
              end
            end
            cfc_pkg::CFC_ST_GROUP:
            begin
              // Basic, interleave and concatenate all drain the group in port order
              pick = rr_pick(grp_ff & member, 2'b11);
              if (!pick[2])
              begin
                nxt_state = cfc_pkg::CFC_ST_HUNT;
              end
              else if (can_send && RX_VALID[pick[1:0]])
              begin
                gnt[pick[1:0]] = 1'b1;
                nxt_grp[pick[1:0]] = 1'b0;
                if ((grp_ff & member) == (4'h1 << pick[1:0]))
                begin
                  nxt_state  = cfc_pkg::CFC_ST_HUNT;
                  nxt_ok     = 1'b1;
                  nxt_synced = 1'b1;
                end
              end
            end
            default: nxt_state = cfc_pkg::CFC_ST_HUNT;
          endcase
        end
        else
        begin
          nxt_state = cfc_pkg::CFC_ST_HUNT;
          if (rr_en)
          begin
            pick = rr_pick(cand, ptr_ff);
            if (pick[2] && can_send)
            begin
              gnt[pick[1:0]] = 1'b1;
              nxt_ptr = pick[1:0];
            end
          end
        end
      end

      assign lost_set[o]  = lset;
      assign synced_ff[o] = sync_ff;
      assign gnt_vec[o]   = gnt;
      assign push[o]      = gnt != 4'h0;
      assign push_src[o]  = pick[1:0];
      assign push_long[o] = RX_LONG[pick[1:0]];
      assign push_data[o] = RX_DATA[pick[1:0]];
      assign load = (repl && o == 1) ? push[0] : push[o];

      always_ff @(posedge CLK)
      begin
        if (!RSTN)
        begin
          state_ff     <= cfc_pkg::CFC_ST_HUNT;
          ptr_ff       <= 2'b11;
          grp_ff       <= 4'h0;
          ok_ff        <= 1'b0;
          sync_ff      <= 1'b0;
          ovalid_ff    <= 1'b0;
          olong_ff     <= 1'b0;
          osrc_ff      <= 2'b00;
          odata_ff     <= 16'h0000;
        end
        else
        begin
          state_ff     <= nxt_state;
          ptr_ff       <= nxt_ptr;
          grp_ff       <= nxt_grp;
          ok_ff        <= nxt_ok;
          sync_ff      <= nxt_synced;
          if (load)
          begin
            ovalid_ff <= 1'b1;
            olong_ff  <= (repl && o == 1) ? push_long[0] : push_long[o];
            osrc_ff   <= (repl && o == 1) ? push_src[0] : push_src[o];
            odata_ff  <= (repl && o == 1) ? push_data[0] : push_data[o];
          end
          else if (take)
          begin
            ovalid_ff <= 1'b0;
          end
        end
      end

      assign OUT_VALID[o] = ovalid_ff;
      assign OUT_LONG[o]  = olong_ff;
      assign OUT_SRC[o]   = osrc_ff;
      assign OUT_DATA[o]  = odata_ff;

      off_port_block_a: assert property (push[o] |-> !rx_off[push_src[o]])
        else $error("Disabled port forwarded");
      route_by_select_a: assert property (push[o] |-> rx_sel[push_src[o]] == 1'(o))
        else $error("Port sent to wrong output");
      sync_hold_line_a: assert property ((push[o] && align != cfc_pkg::CFC_AL_OFF && !asav)
          |-> state_ff == cfc_pkg::CFC_ST_GROUP)
        else $error("Aligned line sent before group complete");
      as_avail_long_a: assert property ((push[o] && state_ff == cfc_pkg::CFC_ST_HUNT
          && align != cfc_pkg::CFC_AL_OFF)
          |-> asav && push_long[o] && align != cfc_pkg::CFC_AL_CAT)
        else $error("Early send outside long packets");
      best_effort_off_a: assert property ((!rr_en && align == cfc_pkg::CFC_AL_OFF)
          |-> !push[o])
        else $error("Forwarding with both modes off");
      rr_rotate_ptr_a: assert property ((push[o] && align == cfc_pkg::CFC_AL_OFF)
          |=> ptr_ff == $past(push_src[o]))
        else $error("Round-robin pointer not advanced");
      lost_after_ok_a: assert property ($rose(lost_ff[o]) |-> $past(ok_ff))
        else $error("Align lost before any good group");
      out_data_load_a: assert property ((load && !(repl && o == 1)) |=> OUT_VALID[o]
          && OUT_DATA[o] == $past(push_data[o]))
        else $error("Output stage did not load");
      group_done_c: cover property (state_ff == cfc_pkg::CFC_ST_GROUP
          ##1 state_ff == cfc_pkg::CFC_ST_HUNT && synced_ff[o]);
      early_send_c: cover property (push[o] && state_ff == cfc_pkg::CFC_ST_HUNT && asav);
    end
  endgenerate

  reset_values_a: assert property ($past(!RSTN) |-> map_ff == `CFC_RST_PORTMAP
      && mode_ff == `CFC_RST_MODE)
    else $error("Control registers not at reset values");
  replicate_copy_a: assert property ((repl && push[0] && $past(repl) == repl) |=> OUT_VALID[1]
      && OUT_DATA[1] == OUT_DATA[0] && OUT_SRC[1] == OUT_SRC[0])
    else $error("Replicated output differs");
  lost_read_clr_a: assert property ((rd_status && lost_set == 2'b00) |=> lost_ff == 2'b00)
    else $error("Align-lost flag not cleared on read");
  replicate_c: cover property (repl && push[0]);
  lost_set_c: cover property ($rose(lost_ff[0]));

endmodule : cfc_forward_ctrl
`default_nettype wire

//--- rtl/cfc_pkg.sv
`default_nettype none
package cfc_pkg;

  typedef enum logic [1:0] {
    CFC_ST_HUNT  = 2'b01,
    CFC_ST_GROUP = 2'b10
  } cfc_state_t;

  typedef enum logic [1:0] {
    CFC_AL_OFF   = 2'b00,
    CFC_AL_BASIC = 2'b01,
    CFC_AL_ILV   = 2'b10,
    CFC_AL_CAT   = 2'b11
  } cfc_align_t;

endpackage : cfc_pkg
`default_nettype wire

//--- sim/cfc_sink.sv
`timescale 1ns/1ns
`default_nettype none
module cfc_sink (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       slow,
  output logic      [1:0] out_ready
);
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  // Unequal stall patterns so the two outputs back up at different times
  always_comb
  begin
    nxt_cnt   = cnt_ff + 3'h1;
    out_ready = slow ? {cnt_ff[1:0] == 2'h0, cnt_ff != 3'h5} : 2'h3;
  end
  always_ff @(posedge clk)
  begin
    if (!rstn)
      cnt_ff <= 3'h0;
    else
      cnt_ff <= nxt_cnt;
  end
endmodule : cfc_sink
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic             clk, rstn, wr, rd, slow, al, rr;
  logic [7:0]       addr, wdata, rdata, mm, md;
  logic [3:0]       rx_valid, rx_ready, rx_long, want;
  logic [3:0][15:0] rx_data;
  logic [1:0]       out_valid, out_ready, out_long;
  logic [1:0][1:0]  out_src;
  logic [1:0][15:0] out_data;
  logic [31:0]      seed;
  logic [16:0]      q[8][$];
  int               n_errors, comparisons, lst, k, o, o2, a, m, b;
  int               n_out[2];

  cfc_forward_ctrl DUT (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_LONG(rx_long),
    .RX_DATA(rx_data), .OUT_VALID(out_valid), .OUT_READY(out_ready), .OUT_LONG(out_long),
    .OUT_SRC(out_src), .OUT_DATA(out_data));
  cfc_sink sink (.clk(clk), .rstn(rstn), .slow(slow), .out_ready(out_ready));

  function logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function int total;
    total = 0;
    foreach (q[i]) total += q[i].size();
  endfunction : total

  task finish_test;
    $display("n_errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task bus_wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (ad == 8'h20) mm <= d;
    if (ad == 8'h21) md <= d;
  endtask : bus_wr

  task bus_rd(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    check(rdata, exp);
  endtask : bus_rd

  task drain;
    want <= 4'h0;
    cyc(4);
    for (int i = 0; i < 500 && total() != 0; i++) cyc(1);
    check(total(), 0);
    if (total() != 0) finish_test();
  endtask : drain

  task flush;
    bus_wr(8'h20, 8'hF0);
    cyc(4);
  endtask : flush

  // Disabled ports are drained, so their words are never queued
  always @(posedge clk)
  begin
    for (int n = 0; n < 4; n++)
    begin
      if (rstn && rx_valid[n] && rx_ready[n] && !mm[4 + n])
      begin
        o = md[7] ? 0 : int'(mm[n]);
        q[o * 4 + n].push_back({rx_long[n], rx_data[n]});
        if (md[7]) q[4 + n].push_back({rx_long[n], rx_data[n]});
      end
      seed = lfsr(seed);
      if (!rx_valid[n] || rx_ready[n])
      begin
        rx_valid[n] <= want[n];
        rx_long[n] <= seed[5] | al;
        rx_data[n] <= seed[15:0];
      end
    end
  end

  always @(posedge clk)
  begin
    if (rstn)
      for (int j = 0; j < 2; j++)
        // Copy mode releases output 0 only when both sinks accept
        if (out_valid[j] && out_ready[j] && (j == 1 || !md[7] || out_ready[1]))
        begin
          k = j * 4 + int'(out_src[j]);
          n_out[j]++;
          if (q[k].size() == 0)
            check(1, 0);
          else
            check({out_long[j], out_data[j]}, q[k].pop_front());
          if (rr && j == 0)
          begin
            check(out_src[0], lst == 3 ? 1 : lst + 1);
            lst = out_src[0];
          end
        end
  end

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    {rstn, wr, rd, slow, al, rr, addr, wdata} = '0;
    {want, rx_valid, rx_long, rx_data} = '0;
    mm = 8'hF0;
    md = 8'h03;
    seed = 32'hf7b4_8ab3;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    bus_rd(8'h20, 8'hF0);
    bus_rd(8'h21, 8'h03);
    bus_rd(8'h30, 8'h00);
    bus_wr(8'h21, 8'h58);
    bus_rd(8'h21, 8'h58);
    bus_wr(8'h21, 8'h03);
    bus_wr(8'h20, 8'h10);
    rr <= 1'b1;
    want <= 4'hF;
    cyc(60);
    rr <= 1'b0;
    drain();
    flush();
    bus_wr(8'h20, 8'h84);
    slow <= 1'b1;
    want <= 4'hF;
    cyc(200);
    drain();
    flush();
    al <= 1'b1;
    for (int j = 0; j < 12; j++)
    begin
      o2 = j / 6;
      a = j / 3 % 2;
      m = j % 3 + 1;
      bus_wr(8'h20, o2 != 0 ? 8'hC3 : 8'hC0);
      bus_wr(8'h21, 8'((a << 6) | (m << (2 + 2 * o2)) | (o2 != 0 ? 1 : 2)));
      b = n_out[o2];
      want <= 4'h1;
      cyc(10);
      check(n_out[o2] != b, a != 0 && m != 3);
      want <= 4'h3;
      cyc(10);
      drain();
      bus_rd(8'h22, 8'(1 << o2));
      flush();
    end
    bus_wr(8'h21, 8'h83);
    bus_wr(8'h20, 8'hE0);
    want <= 4'h1;
    cyc(60);
    drain();
    finish_test();
  end
endmodule : tb
`default_nettype wire
